/* rtl/fsp_pkg.sv */
// constants for the fuse, signature and parallel programming port block
package fsp_pkg;
   // clock
   localparam int CLK_PERIOD_NS = 10;
   // least control pulse width
   localparam int PULSE_MIN_NS = 250;
   localparam int PULSE_MIN_CYCLES = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // busy time of one write
   localparam int PROG_TIME_NS = 2000;
   localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PROG_CNT_W = 16;

   // reset values, 0 = programmed
   localparam logic [7:0] EXT_CONFIG_RESET = 8'hFF;
   localparam logic [7:0] HIGH_CONFIG_RESET = 8'h99;
   localparam logic [7:0] LOW_CONFIG_RESET = 8'h62;
   localparam logic [7:0] LOCK_BYTE_RESET = 8'hFF;

   // field positions
   localparam int EXT_RESET_DISABLE_BIT = 0;
   localparam int EXT_BROWNOUT_LSB = 1;
   localparam int EXT_BROWNOUT_MSB = 3;
   localparam int HIGH_DEBUG_UNIT_BIT = 7;
   localparam int HIGH_BOUNDARY_PORT_BIT = 6;
   localparam int HIGH_SERIAL_DOWNLOAD_BIT = 5;
   localparam int HIGH_WATCHDOG_BIT = 4;
   localparam int HIGH_EEPROM_KEEP_BIT = 3;
   localparam int HIGH_BOOT_SIZE_LSB = 1;
   localparam int HIGH_RESET_VECTOR_BIT = 0;
   localparam int LOW_CLOCK_DIV_EIGHT_BIT = 7;
   localparam int LOW_CLOCK_PIN_DRIVE_BIT = 6;
   localparam int LOW_STARTUP_LSB = 4;
   localparam int LOW_CLOCK_SOURCE_LSB = 0;
   localparam int LOCK_MEMLOCK_BIT1 = 0;
   localparam int LOCK_MEMLOCK_BIT2 = 1;

   // page geometry
   localparam int FLASH_WORD_BITS = 6;
   localparam int FLASH_PAGE_BITS = 7;
   localparam int EE_BYTE_BITS = 2;
   localparam int EE_PAGE_BITS = 7;

   // signature space addresses
   localparam logic [7:0] SIG_ADDR_0 = 8'h00;
   localparam logic [7:0] SIG_ADDR_1 = 8'h01;
   localparam logic [7:0] SIG_ADDR_2 = 8'h02;

   // pulse action encoding
   localparam logic [1:0] ACT_LOAD_ADDR = 2'h0;
   localparam logic [1:0] ACT_LOAD_DATA = 2'h1;
   localparam logic [1:0] ACT_LOAD_CMD = 2'h2;
   localparam logic [1:0] ACT_IDLE = 2'h3;

   // command bytes
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
   localparam logic [7:0] CMD_WRITE_FUSES = 8'h40;
   localparam logic [7:0] CMD_WRITE_LOCKS = 8'h20;
   localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
   localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
   localparam logic [7:0] CMD_READ_SIG = 8'h08;
   localparam logic [7:0] CMD_READ_FUSES = 8'h04;
   localparam logic [7:0] CMD_READ_FLASH = 8'h02;
   localparam logic [7:0] CMD_READ_EEPROM = 8'h03;
   localparam logic [7:0] CMD_RESET = 8'h00;
endpackage

/* rtl/fsp_fuse_if.sv */
// port controller to fuse store carrier
`timescale 1ns/10ps
`default_nettype none
interface fsp_fuse_if;
   logic [7:0] wdata;
   logic wr_fuse;
   logic sel_high;
   logic sel_ext;
   logic wr_lock;
   logic erase;
   logic serial_path;
   logic prog_mode;
   logic [7:0] stored_ext;
   logic [7:0] stored_high;
   logic [7:0] stored_low;
   logic [7:0] stored_lock;
   logic [7:0] active_ext;
   logic [7:0] active_high;
   logic [7:0] active_low;
   logic eeprom_keep;
   modport ctrl(output wdata, wr_fuse, sel_high, sel_ext, wr_lock, erase, serial_path,
      prog_mode, input stored_ext, stored_high, stored_low, stored_lock, active_ext,
      active_high, active_low, eeprom_keep);
   modport store(input wdata, wr_fuse, sel_high, sel_ext, wr_lock, erase, serial_path,
      prog_mode, output stored_ext, stored_high, stored_low, stored_lock, active_ext,
      active_high, active_low, eeprom_keep);
endinterface
`default_nettype wire

/* rtl/fsp_pin_sync.sv */
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module fsp_pin_sync #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         meta <= RESET_VALUE;
         q <= RESET_VALUE;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule
`default_nettype wire

/* rtl/fsp_fuse_store.sv */
// nonvolatile fuse and lock bytes with their latched working copies
`timescale 1ns/10ps
`default_nettype none
module fsp_fuse_store (
   input wire logic ref_clk,
   input wire logic rst,
   fsp_fuse_if.store fi
);
   logic prog_mode_d;
   logic powered_up;
   logic locked_out;
   logic [7:0] next_high;
   localparam logic HIGH_KEEP_RESET = fsp_pkg::HIGH_CONFIG_RESET[fsp_pkg::HIGH_EEPROM_KEEP_BIT];

   assign locked_out = ~fi.stored_lock[fsp_pkg::LOCK_MEMLOCK_BIT1];

   // serial path keeps the serial download bit
   always_comb begin
      next_high = fi.wdata;
      if (fi.serial_path) begin
         next_high[fsp_pkg::HIGH_SERIAL_DOWNLOAD_BIT] =
            fi.stored_high[fsp_pkg::HIGH_SERIAL_DOWNLOAD_BIT];
      end
   end

   // stored bytes; erase leaves fuses alone
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fi.stored_ext <= fsp_pkg::EXT_CONFIG_RESET;
         fi.stored_high <= fsp_pkg::HIGH_CONFIG_RESET;
         fi.stored_low <= fsp_pkg::LOW_CONFIG_RESET;
      end else if (fi.wr_fuse && !locked_out) begin
         if (fi.sel_ext) begin
            fi.stored_ext <= fi.wdata | 8'hF0;
         end else if (fi.sel_high) begin
            fi.stored_high <= next_high;
         end else begin
            fi.stored_low <= fi.wdata;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fi.stored_lock <= fsp_pkg::LOCK_BYTE_RESET;
      end else if (fi.erase) begin
         fi.stored_lock <= fsp_pkg::LOCK_BYTE_RESET;
      end else if (fi.wr_lock) begin
         fi.stored_lock <= fi.stored_lock & (fi.wdata | 8'hC0);
      end
   end

   // working copies taken at power-up and mode changes
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prog_mode_d <= 1'b0;
         powered_up <= 1'b0;
         fi.active_ext <= fsp_pkg::EXT_CONFIG_RESET;
         fi.active_high <= fsp_pkg::HIGH_CONFIG_RESET;
         fi.active_low <= fsp_pkg::LOW_CONFIG_RESET;
      end else begin
         prog_mode_d <= fi.prog_mode;
         powered_up <= 1'b1;
         if (!powered_up || (fi.prog_mode != prog_mode_d)) begin
            fi.active_ext <= fi.stored_ext;
            fi.active_high <= fi.stored_high;
            fi.active_low <= fi.stored_low;
         end
      end
   end

   // keep fuse acts at once
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fi.eeprom_keep <= HIGH_KEEP_RESET;
      end else begin
         fi.eeprom_keep <= fi.stored_high[fsp_pkg::HIGH_EEPROM_KEEP_BIT];
      end
   end

endmodule
`default_nettype wire

/* rtl/fsp_top.sv */
// parallel programming port with fuse store, signature and page buffers
`timescale 1ns/10ps
`default_nettype none
// How it works
// - fuses read 0 programmed, 1 unprogrammed
// - extended byte: brown-out level, reset disable
// - high byte fields and their defaults
// - serial path cannot change serial download
// - low byte fields, internal oscillator default
// - chip erase leaves fuses unchanged
// - fuse writes refused when lock bit1 programmed
// - fuses latched on entering programming mode
// - eeprom keep fuse acts immediately
// - fuses also latched at power-up
// - three signature bytes, readable even locked
// - calibration byte copied to trim at reset
// - flash 128 pages of 64 words
// - eeprom 128 pages of 4 bytes
// - action selects choose load on clock pulse
// - action codes: address, data, command, idle
// - write/output strobes run loaded command
// - command byte encodings
// - ready/busy low while operation runs
// - data bus driven only while output enable low
// - byte selects choose low/high/second high byte
// - page latch strobe loads the page buffer
module fsp_top #(
   parameter logic [7:0] SIG_BYTE0 = 8'hA5, // arbitrary identity value
   parameter logic [7:0] SIG_BYTE1 = 8'h3C, // arbitrary identity value
   parameter logic [7:0] SIG_BYTE2 = 8'h71, // arbitrary identity value
   parameter logic [7:0] CAL_BYTE = 8'h80,
   parameter int FLASH_WORDS = 64,
   parameter int EE_BYTES = 4
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic prog_voltage_det,
   input wire logic serial_path_active,
   input wire logic pulse_clock_pin,
   input wire logic pulse_action_sel1,
   input wire logic pulse_action_sel0,
   input wire logic byte_choice_a,
   input wire logic byte_choice_b,
   input wire logic buffer_latch_strobe,
   input wire logic write_strobe_n,
   input wire logic out_enable_n,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic prog_ready_n_busy,
   output logic [7:0] extended_config_byte,
   output logic [7:0] high_config_byte,
   output logic [7:0] low_config_byte,
   output logic eeprom_keep_on_erase,
   output logic [7:0] rc_trim_register,
   output logic [fsp_pkg::FLASH_WORD_BITS-1:0] flash_word_index,
   output logic [fsp_pkg::FLASH_PAGE_BITS-1:0] flash_page_index,
   output logic [8:0] eeprom_addr_bits
);
   typedef enum logic [1:0] {FSP_IDLE, FSP_BUSY, FSP_DONE} fsp_state_t;

   localparam int PIN_W = 24;

   fsp_fuse_if fi();

   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_s;
   logic [PIN_W-1:0] pin_d;
   logic prog_mode;
   logic clk_rise;
   logic latch_rise;
   logic wr_fall;
   logic [1:0] action;
   logic bs_a;
   logic bs_b;
   logic oe_low;
   logic [7:0] bus;

   logic [7:0] command;
   logic [7:0] addr_lo;
   logic [7:0] addr_hi;
   logic [7:0] data_lo;
   logic [7:0] data_hi;
   logic [15:0] flash_buf [FLASH_WORDS];
   logic [7:0] ee_buf [EE_BYTES];
   fsp_state_t state;
   logic [fsp_pkg::PROG_CNT_W-1:0] busy_cnt;
   logic [7:0] next_read;
   logic [8:0] ee_addr;

   assign pin_raw = {data_in, prog_voltage_det, serial_path_active, pulse_clock_pin,
      pulse_action_sel1, pulse_action_sel0, byte_choice_a, byte_choice_b,
      buffer_latch_strobe, write_strobe_n, out_enable_n, 6'h00};

   fsp_pin_sync #(
      .WIDTH(PIN_W),
      .RESET_VALUE(24'h0000C0)
   ) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .d(pin_raw),
      .q(pin_s)
   );

   fsp_fuse_store u_store (
      .ref_clk(ref_clk),
      .rst(rst),
      .fi(fi)
   );

   // edge history of synced pins
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pin_d <= 24'h0000C0;
      end else begin
         pin_d <= pin_s;
      end
   end

   assign prog_mode = pin_s[15];
   assign action = pin_s[12:11];
   assign bs_a = pin_s[10];
   assign bs_b = pin_s[9];
   assign oe_low = prog_mode && !pin_s[6];
   assign clk_rise = prog_mode && pin_s[13] && !pin_d[13];
   assign latch_rise = prog_mode && pin_s[8] && !pin_d[8];
   assign wr_fall = prog_mode && !pin_s[7] && pin_d[7];
   // data pins pass the same two flops as the strobes
   assign bus = pin_s[23:16];

   // loads on pulse clock rising edge
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         command <= fsp_pkg::CMD_RESET;
         addr_lo <= 8'h00;
         addr_hi <= 8'h00;
         data_lo <= 8'hFF;
         data_hi <= 8'hFF;
      end else if (!prog_mode) begin
         command <= fsp_pkg::CMD_RESET;
      end else if (clk_rise) begin
         unique case (action)
            fsp_pkg::ACT_LOAD_ADDR: begin
               if (bs_a) begin
                  addr_hi <= bus;
               end else begin
                  addr_lo <= bus;
               end
            end
            fsp_pkg::ACT_LOAD_DATA: begin
               if (bs_a) begin
                  data_hi <= bus;
               end else begin
                  data_lo <= bus;
               end
            end
            fsp_pkg::ACT_LOAD_CMD: command <= bus;
            fsp_pkg::ACT_IDLE: ;
         endcase
      end
   end

   assign ee_addr = {addr_hi[0], addr_lo};

   // page buffers filled by the page latch strobe
   always_ff @(posedge ref_clk) begin
      if (latch_rise && command == fsp_pkg::CMD_WRITE_FLASH) begin
         flash_buf[addr_lo[fsp_pkg::FLASH_WORD_BITS-1:0]] <= {data_hi, data_lo};
      end
      if (latch_rise && command == fsp_pkg::CMD_WRITE_EEPROM) begin
         ee_buf[addr_lo[fsp_pkg::EE_BYTE_BITS-1:0]] <= data_lo;
      end
      if (state == FSP_IDLE && wr_fall && command == fsp_pkg::CMD_CHIP_ERASE &&
            fi.eeprom_keep) begin
         for (int i = 0; i < EE_BYTES; i++) begin
            ee_buf[i] <= 8'hFF;
         end
      end
   end

   // write strobe starts the command; busy for a fixed count
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= FSP_IDLE;
         busy_cnt <= '0;
      end else begin
         unique case (state)
            FSP_IDLE: begin
               if (wr_fall) begin
                  state <= FSP_BUSY;
                  busy_cnt <= fsp_pkg::PROG_CNT_W'(fsp_pkg::PROG_CYCLES - 1);
               end
            end
            FSP_BUSY: begin
               if (busy_cnt == '0) begin
                  state <= FSP_DONE;
               end else begin
                  busy_cnt <= busy_cnt - 1'b1;
               end
            end
            FSP_DONE: state <= FSP_IDLE;
         endcase
      end
   end

   // one-cycle requests to the fuse store
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fi.wr_fuse <= 1'b0;
         fi.wr_lock <= 1'b0;
         fi.erase <= 1'b0;
         fi.wdata <= 8'hFF;
         fi.sel_high <= 1'b0;
         fi.sel_ext <= 1'b0;
      end else begin
         fi.wr_fuse <= state == FSP_IDLE && wr_fall && command == fsp_pkg::CMD_WRITE_FUSES;
         fi.wr_lock <= state == FSP_IDLE && wr_fall && command == fsp_pkg::CMD_WRITE_LOCKS;
         fi.erase <= state == FSP_IDLE && wr_fall && command == fsp_pkg::CMD_CHIP_ERASE;
         fi.wdata <= data_lo;
         fi.sel_high <= bs_a;
         fi.sel_ext <= bs_b;
      end
   end

   assign fi.serial_path = pin_s[14];
   assign fi.prog_mode = prog_mode;

   // read data by command and byte selects
   always_comb begin
      next_read = 8'hFF;
      unique case (command)
         fsp_pkg::CMD_READ_SIG: begin
            if (bs_a) begin
               next_read = (addr_lo == fsp_pkg::SIG_ADDR_0) ? CAL_BYTE : 8'hFF;
            end else if (addr_lo == fsp_pkg::SIG_ADDR_0) begin
               next_read = SIG_BYTE0;
            end else if (addr_lo == fsp_pkg::SIG_ADDR_1) begin
               next_read = SIG_BYTE1;
            end else if (addr_lo == fsp_pkg::SIG_ADDR_2) begin
               next_read = SIG_BYTE2;
            end
         end
         fsp_pkg::CMD_READ_FUSES: begin
            unique case ({bs_b, bs_a})
               2'h0: next_read = fi.stored_low;
               2'h1: next_read = fi.stored_lock;
               2'h2: next_read = fi.stored_ext;
               2'h3: next_read = fi.stored_high;
            endcase
         end
         fsp_pkg::CMD_READ_FLASH: begin
            if (fi.stored_lock[fsp_pkg::LOCK_MEMLOCK_BIT2]) begin
               next_read = bs_a ? flash_buf[addr_lo[fsp_pkg::FLASH_WORD_BITS-1:0]][15:8] :
                  flash_buf[addr_lo[fsp_pkg::FLASH_WORD_BITS-1:0]][7:0];
            end
         end
         fsp_pkg::CMD_READ_EEPROM: begin
            if (fi.stored_lock[fsp_pkg::LOCK_MEMLOCK_BIT2]) begin
               next_read = ee_buf[addr_lo[fsp_pkg::EE_BYTE_BITS-1:0]];
            end
         end
         default: next_read = 8'hFF;
      endcase
   end

   // drive bus only while enabled
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         data_oe <= 1'b0;
         data_out <= 8'h00;
      end else begin
         data_oe <= oe_low;
         data_out <= oe_low ? next_read : 8'h00;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prog_ready_n_busy <= 1'b1;
      end else begin
         prog_ready_n_busy <= (state == FSP_IDLE) && !wr_fall;
      end
   end

   // working fuses and addressing
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         extended_config_byte <= fsp_pkg::EXT_CONFIG_RESET;
         high_config_byte <= fsp_pkg::HIGH_CONFIG_RESET;
         low_config_byte <= fsp_pkg::LOW_CONFIG_RESET;
         eeprom_keep_on_erase <= fsp_pkg::HIGH_CONFIG_RESET[fsp_pkg::HIGH_EEPROM_KEEP_BIT];
         flash_word_index <= '0;
         flash_page_index <= '0;
         eeprom_addr_bits <= '0;
      end else begin
         extended_config_byte <= fi.active_ext;
         high_config_byte <= fi.active_high;
         low_config_byte <= fi.active_low;
         eeprom_keep_on_erase <= fi.eeprom_keep;
         flash_word_index <= addr_lo[fsp_pkg::FLASH_WORD_BITS-1:0];
         flash_page_index <= {addr_hi[4:0], addr_lo[7:6]};
         eeprom_addr_bits <= ee_addr;
      end
   end

   // trim takes the calibration byte during reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rc_trim_register <= CAL_BYTE;
      end else begin
         rc_trim_register <= rc_trim_register;
      end
   end
endmodule
`default_nettype wire

/* tb/fsp_top_props.sv */
// concurrent checks on the port handshake and the fuse working copies
`timescale 1ns/10ps
`default_nettype none
module fsp_top_props #(
   parameter logic [7:0] CAL_BYTE = 8'h80
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic prog_voltage_det,
   input wire logic write_strobe_n,
   input wire logic out_enable_n,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   input wire logic prog_ready_n_busy,
   input wire logic [7:0] extended_config_byte,
   input wire logic [7:0] high_config_byte,
   input wire logic [7:0] low_config_byte,
   input wire logic eeprom_keep_on_erase,
   input wire logic [7:0] rc_trim_register
);
   logic [8:0] busy_cnt;
   logic [3:0] mode_age;
   logic mode_prev;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // busy phase length
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         busy_cnt <= 9'h000;
      end else begin
         busy_cnt <= prog_ready_n_busy ? 9'h000 : busy_cnt + 9'h001;
      end
   end
   // saturating age of the mode pin
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode_prev <= 1'b0;
         mode_age <= 4'h0;
      end else begin
         mode_prev <= prog_voltage_det;
         if (mode_prev != prog_voltage_det) begin
            mode_age <= 4'h0;
         end else if (mode_age != 4'hF) begin
            mode_age <= mode_age + 4'h1;
         end
      end
   end
   a_bus_release: assert property (out_enable_n [*5] |-> !data_oe)
      else $error("bus driven while released");
   a_idle_data_zero: assert property (!data_oe |-> data_out == 8'h00)
      else $error("idle read data not zero");
   a_busy_span: assert property ($rose(prog_ready_n_busy) |-> busy_cnt == 9'(fsp_pkg::PROG_CYCLES + 2))
      else $error("wrong busy length");
   a_busy_cause: assert property ($fell(prog_ready_n_busy) |-> $past(write_strobe_n, 2) == 1'b0)
      else $error("busy without write strobe");
   a_ext_unused: assert property (extended_config_byte[7:4] == 4'hF)
      else $error("unused extended bits not one");
   a_fuse_latch: assert property (!$stable({extended_config_byte, high_config_byte, low_config_byte})
      |-> mode_age < 4'h8)
      else $error("working fuses changed in mode");
   a_keep_live: assert property ($changed(eeprom_keep_on_erase) |-> !prog_ready_n_busy || mode_age < 4'h8)
      else $error("keep fuse changed outside a write");
   a_trim_cal: assert property (rc_trim_register == CAL_BYTE)
      else $error("trim differs from cal byte");
   c_write_done: cover property ($rose(prog_ready_n_busy));
   c_bus_read: cover property ($rose(data_oe));
   c_fuse_latched: cover property ($changed(low_config_byte));
endmodule
bind fsp_top fsp_top_props #(.CAL_BYTE(CAL_BYTE)) u_props (.ref_clk, .rst, .prog_voltage_det,
   .write_strobe_n, .out_enable_n, .data_out, .data_oe, .prog_ready_n_busy, .extended_config_byte,
   .high_config_byte, .low_config_byte, .eeprom_keep_on_erase, .rc_trim_register);
`default_nettype wire

/* tb/fsp_prog_model.sv */
// behavioural parallel programmer on the far side of the port pins
`timescale 1ns/10ps
`default_nettype none
module fsp_prog_model (
   input wire logic ref_clk,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   input wire logic prog_ready_n_busy,
   output logic pulse_clock_pin,
   output logic pulse_action_sel1,
   output logic pulse_action_sel0,
   output logic byte_choice_a,
   output logic byte_choice_b,
   output logic buffer_latch_strobe,
   output logic write_strobe_n,
   output logic out_enable_n,
   output logic [7:0] bus_drive
);
   localparam int HOLD = 25;
   initial begin
      {pulse_clock_pin, buffer_latch_strobe, write_strobe_n, out_enable_n} = 4'h3;
   end
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic park();
      {buffer_latch_strobe, pulse_action_sel1, pulse_action_sel0, byte_choice_a} = 4'h0;
   endtask
   task automatic pulse(input logic [1:0] act, input logic bs1, input logic [7:0] d);
      {pulse_action_sel1, pulse_action_sel0} = act;
      byte_choice_a = bs1;
      bus_drive = d;
      wait_cyc(HOLD);
      pulse_clock_pin = 1'b1;
      wait_cyc(HOLD);
      pulse_clock_pin = 1'b0;
      wait_cyc(HOLD);
      // no stale value
      bus_drive = ~d;
   endtask
   task automatic latch();
      buffer_latch_strobe = 1'b1;
      wait_cyc(HOLD);
      buffer_latch_strobe = 1'b0;
      wait_cyc(HOLD);
   endtask
   task automatic write(input logic bs1, input logic bs2, output logic seen);
      int n;
      {byte_choice_a, byte_choice_b} = {bs1, bs2};
      seen = 1'b0;
      wait_cyc(HOLD);
      write_strobe_n = 1'b0;
      for (n = 0; n < HOLD; n++) begin
         wait_cyc(1);
         seen |= (prog_ready_n_busy === 1'b0);
      end
      write_strobe_n = 1'b1;
      for (n = 0; n < 1000 && prog_ready_n_busy !== 1'b1; n++) begin
         wait_cyc(1);
      end
      wait_cyc(HOLD);
   endtask
   task automatic read(input logic bs1, input logic bs2, output logic [7:0] q);
      {byte_choice_a, byte_choice_b} = {bs1, bs2};
      wait_cyc(HOLD);
      out_enable_n = 1'b0;
      wait_cyc(HOLD);
      q = (data_oe === 1'b1) ? data_out : 8'hXX;
      out_enable_n = 1'b1;
      wait_cyc(HOLD);
   endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the fuse, signature and parallel port block
`timescale 1ns/10ps
`default_nettype none
module testbench;
   localparam logic [7:0] CAL = 8'h5A;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic prog_voltage_det = 1'b0;
   logic serial_path_active = 1'b0;
   logic pulse_clock_pin, pulse_action_sel1, pulse_action_sel0, byte_choice_a, byte_choice_b;
   logic buffer_latch_strobe, write_strobe_n, out_enable_n, data_oe, prog_ready_n_busy, b;
   logic eeprom_keep_on_erase;
   logic [7:0] bus_drive, data_out, bus, extended_config_byte, high_config_byte, q;
   logic [7:0] low_config_byte, rc_trim_register;
   logic [5:0] flash_word_index;
   logic [6:0] flash_page_index;
   logic [8:0] eeprom_addr_bits;
   logic [15:0] addr, fd;
   logic [7:0] sig [4] = '{8'h4B, 8'hD2, 8'h17, CAL};
   int fails = 0;
   int cmp_count = 0;
   // stored bytes: low, lock, ext, high
   int m [4] = '{8'h62, 8'hFF, 8'hFF, 8'h99};
   int s [3];
   assign bus = data_oe ? data_out : bus_drive;
   always #5 ref_clk = ~ref_clk;
   fsp_top #(.SIG_BYTE0(8'h4B), .SIG_BYTE1(8'hD2), .SIG_BYTE2(8'h17), .CAL_BYTE(CAL)) uut (
      .ref_clk, .rst, .prog_voltage_det, .serial_path_active, .pulse_clock_pin,
      .pulse_action_sel1, .pulse_action_sel0, .byte_choice_a, .byte_choice_b,
      .buffer_latch_strobe, .write_strobe_n, .out_enable_n, .data_in(bus), .data_out, .data_oe,
      .prog_ready_n_busy, .extended_config_byte, .high_config_byte, .low_config_byte,
      .eeprom_keep_on_erase, .rc_trim_register, .flash_word_index, .flash_page_index,
      .eeprom_addr_bits);
   fsp_prog_model prog (.ref_clk, .data_out, .data_oe, .prog_ready_n_busy, .pulse_clock_pin,
      .pulse_action_sel1, .pulse_action_sel0, .byte_choice_a, .byte_choice_b,
      .buffer_latch_strobe, .write_strobe_n, .out_enable_n, .bus_drive);
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      if (fails == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic cmd(input logic [7:0] c);
      prog.pulse(fsp_pkg::ACT_LOAD_CMD, 1'b0, c);
   endtask
   task automatic wr_op(input logic [7:0] c, input logic [7:0] d, input logic [1:0] sel);
      cmd(c);
      prog.pulse(fsp_pkg::ACT_LOAD_DATA, 1'b0, d);
      prog.write(sel[0], sel[1], b);
      check("busy seen", 16'(b), 16'h0001);
   endtask
   task automatic wfuse(input int sel, input logic [7:0] v);
      wr_op(fsp_pkg::CMD_WRITE_FUSES, v, (sel == 3) ? 2'h1 : 2'(sel));
      if (m[1][0]) m[sel] = (sel == 2) ? (v | 8'hF0) : (sel == 3 && serial_path_active) ?
         ((v & 8'hDF) | (m[3] & 8'h20)) : v;
   endtask
   task automatic rd_fuses();
      cmd(fsp_pkg::CMD_READ_FUSES);
      for (int i = 0; i < 4; i++) begin
         prog.read(i[0], i[1], q);
         check("fuse byte", 16'(q), 16'(m[i]));
      end
   endtask
   task automatic mode(input logic on);
      prog.park();
      prog.wait_cyc(10);
      prog_voltage_det = on;
      prog.wait_cyc(20);
      s = '{m[0], m[3], m[2]};
   endtask
   task automatic chk_work(input int l, input int h, input int e);
      check("low_config_byte", 16'(low_config_byte), 16'(l));
      check("high_config_byte", 16'(high_config_byte), 16'(h));
      check("extended_config_byte", 16'(extended_config_byte), 16'(e));
   endtask
   initial begin
      void'($urandom(95554));
      prog.wait_cyc(5);
      rst = 1'b0;
      prog.wait_cyc(5);
      chk_work(8'h62, 8'h99, 8'hFF);
      check("rc_trim_register", 16'(rc_trim_register), 16'(CAL));
      mode(1'b1);
      cmd(fsp_pkg::CMD_READ_SIG);
      for (int i = 0; i < 4; i++) begin
         prog.pulse(fsp_pkg::ACT_LOAD_ADDR, 1'b0, 8'(i % 3));
         prog.read(i == 3, 1'b0, q);
         check("signature", 16'(q), 16'(sig[i]));
      end
      serial_path_active = 1'b1;
      wfuse(3, 8'hB9);
      serial_path_active = 1'b0;
      wfuse(3, 8'h91);
      check("eeprom_keep_on_erase", 16'(eeprom_keep_on_erase), 16'h0000);
      wfuse(0, 8'($urandom));
      wfuse(2, 8'($urandom));
      rd_fuses();
      chk_work(s[0], s[1], s[2]);
      wr_op(fsp_pkg::CMD_CHIP_ERASE, 8'hFF, 2'h0);
      rd_fuses();
      addr = 16'($urandom);
      cmd(fsp_pkg::CMD_WRITE_FLASH);
      prog.pulse(fsp_pkg::ACT_LOAD_ADDR, 1'b0, addr[7:0]);
      prog.pulse(fsp_pkg::ACT_LOAD_ADDR, 1'b1, addr[15:8]);
      prog.pulse(fsp_pkg::ACT_IDLE, 1'b0, ~addr[7:0]);
      check("flash_word_index", 16'(flash_word_index), 16'(addr[5:0]));
      check("flash_page_index", 16'(flash_page_index), 16'(addr[12:6]));
      check("eeprom_addr_bits", 16'(eeprom_addr_bits), 16'(addr[8:0]));
      fd = 16'($urandom);
      prog.pulse(fsp_pkg::ACT_LOAD_DATA, 1'b0, fd[7:0]);
      prog.pulse(fsp_pkg::ACT_LOAD_DATA, 1'b1, fd[15:8]);
      prog.latch();
      cmd(fsp_pkg::CMD_READ_FLASH);
      prog.read(1'b0, 1'b0, q);
      check("flash low byte", 16'(q), 16'(fd[7:0]));
      prog.read(1'b1, 1'b0, q);
      check("flash high byte", 16'(q), 16'(fd[15:8]));
      // fuses final, lock now
      wr_op(fsp_pkg::CMD_WRITE_LOCKS, 8'hFE, 2'h0);
      m[1] = 8'hFE;
      wfuse(0, 8'(~m[0]));
      rd_fuses();
      cmd(fsp_pkg::CMD_READ_SIG);
      prog.pulse(fsp_pkg::ACT_LOAD_ADDR, 1'b0, 8'h02);
      prog.read(1'b0, 1'b0, q);
      check("locked signature", 16'(q), 16'(sig[2]));
      mode(1'b0);
      chk_work(m[0], m[3], m[2]);
      rst = 1'b1;
      prog.wait_cyc(5);
      rst = 1'b0;
      prog.wait_cyc(5);
      chk_work(8'h62, 8'h99, 8'hFF);
      tally_and_finish();
   end
   initial begin
      repeat (40000) @(posedge ref_clk);
      fails++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
